// ==== hw/dgp_port.sv ====
// Purpose: Four-pin and three-pin general-purpose ports with standby pin handling.
// Assumes: STANDBY_MODE and EXT_IRQ_ENABLE come from logic on CORE_CLK.
// Notes: Pin controls update at the same edge as the register that steers them, except the float bit, which acts one edge after it is stored.
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/10ps
`include "dgp_map.svh"
module dgp_port (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic STANDBY_MODE,
    input wire logic [3:0] EXT_IRQ_ENABLE,
    input wire logic [3:0] FOUR_PIN_IN,
    output logic [3:0] FOUR_PIN_OUT,
    output logic [3:0] FOUR_PIN_OE,
    output logic [3:0] FOUR_PIN_PULLUP,
    output logic [3:0] EXT_IRQ_LINE,
    input wire logic [2:0] THREE_PIN_IN,
    output logic [2:0] THREE_PIN_OUT,
    output logic [2:0] THREE_PIN_OE
);
    import dgp_pkg::*;

    dgp_state_t s;
    dgp_state_t next_s;
    dgp_pin_if pin_bus ();

    logic float_active;
    logic [3:0] four_level;
    logic [2:0] three_level;

    dgp_pin_sync u_sync (
        .CORE_CLK(CORE_CLK),
        .SYS_RST(SYS_RST),
        .pins(pin_bus.sync_side)
    );

    assign pin_bus.raw = {FOUR_PIN_IN, THREE_PIN_IN};

    // Word-aligned decode; the two low address bits are ignored.
    function automatic logic reg_hit(input logic [7:0] addr);
        logic [7:0] a;
        a = {addr[7:2], 2'h0};
        case (a)
            `DGP_OFS_FOUR_DATA,
            `DGP_OFS_FOUR_DIR,
            `DGP_OFS_FOUR_PULL,
            `DGP_OFS_THREE_DATA,
            `DGP_OFS_THREE_DIR,
            `DGP_OFS_CTRL,
            `DGP_OFS_FOUR_VIEW,
            `DGP_OFS_THREE_VIEW: reg_hit = 1'h1;
            default: reg_hit = 1'h0;
        endcase
    endfunction : reg_hit

    function automatic logic [7:0] word_of(input logic [7:0] addr);
        word_of = {addr[7:2], 2'h0};
    endfunction : word_of

    // Standby floats the pins only while the float bit is set.
    assign float_active = STANDBY_MODE && s.standby_pin_float_bit;

    // Blocked inputs read low; interrupt-enabled four-pin inputs stay open for wake-up.
    assign four_level = pin_bus.synced.four
        & (float_active ? EXT_IRQ_ENABLE : 4'hF);
    assign three_level = pin_bus.synced.three & {3{~float_active}};

    always_comb begin
        logic [7:0] rd;
        logic [3:0] four_drive;
        logic [2:0] three_drive;
        rd = 8'h00;
        four_drive = 4'h0;
        three_drive = 3'h0;
        next_s = s;

        // Write channel: ready is raised only when address and data are both offered.
        if (s.wr_ready) begin
            next_s.wr_ready = 1'h0;
            next_s.bvalid = 1'h1;
            next_s.bresp = reg_hit(AWADDR) ? `DGP_RESP_OKAY : `DGP_RESP_SLVERR;
            if (WSTRB[0]) begin
                case (word_of(AWADDR))
                    `DGP_OFS_FOUR_DATA: next_s.four_pin_data_latch = WDATA[3:0];
                    `DGP_OFS_FOUR_DIR: next_s.four_pin_direction = WDATA[3:0];
                    `DGP_OFS_FOUR_PULL: next_s.four_pin_pullup_enable = WDATA[3:0];
                    `DGP_OFS_THREE_DATA: next_s.three_pin_data_latch = WDATA[2:0];
                    `DGP_OFS_THREE_DIR: next_s.three_pin_direction = WDATA[2:0];
                    `DGP_OFS_CTRL: begin
                        next_s.standby_pin_float_bit = WDATA[`DGP_CTRL_FLOAT_BIT];
                        next_s.external_reset_select_bit = WDATA[`DGP_CTRL_RSTSEL_BIT];
                    end
                    default: next_s.bresp = next_s.bresp;
                endcase
            end
        end else if (AWVALID && WVALID && !s.bvalid) begin
            next_s.wr_ready = 1'h1;
        end
        if (s.bvalid && BREADY) begin
            next_s.bvalid = 1'h0;
        end

        // Read channel: data reads mix latch and pin per direction bit.
        case (word_of(ARADDR))
            `DGP_OFS_FOUR_DATA: rd = {4'h0, (s.four_pin_data_latch & s.four_pin_direction)
                | (four_level & ~s.four_pin_direction)};
            `DGP_OFS_FOUR_DIR: rd = {4'h0, s.four_pin_direction};
            `DGP_OFS_FOUR_PULL: rd = {4'h0, s.four_pin_pullup_enable};
            `DGP_OFS_THREE_DATA: begin
                rd = {5'h00, (s.three_pin_data_latch & s.three_pin_direction)
                    | (three_level & ~s.three_pin_direction)};
                if (s.external_reset_select_bit) begin
                    rd[`DGP_OD_PIN] = 1'h0;
                end
            end
            `DGP_OFS_THREE_DIR: rd = {5'h00, s.three_pin_direction};
            `DGP_OFS_CTRL: rd = {6'h00, s.external_reset_select_bit, s.standby_pin_float_bit};
            `DGP_OFS_FOUR_VIEW: rd = {4'h0, s.four_pin_data_latch};
            `DGP_OFS_THREE_VIEW: rd = {5'h00, s.three_pin_data_latch};
            default: rd = 8'h00;
        endcase

        if (s.ar_ready) begin
            next_s.ar_ready = 1'h0;
            next_s.rvalid = 1'h1;
            next_s.rdata = rd;
            next_s.rresp = reg_hit(ARADDR) ? `DGP_RESP_OKAY : `DGP_RESP_SLVERR;
        end else if (ARVALID && !s.rvalid) begin
            next_s.ar_ready = 1'h1;
        end
        if (s.rvalid && RREADY) begin
            next_s.rvalid = 1'h0;
        end

        // Pin controls follow the register values being stored this edge; the float bit acts from its already stored value.
        four_drive = next_s.four_pin_direction & {4{~float_active}};
        next_s.four_oe = four_drive;
        next_s.four_out = next_s.four_pin_data_latch;
        // A pin driving low would fight its own pull-up, so the pull-up drops out.
        next_s.four_pullup = next_s.four_pin_pullup_enable & {4{~float_active}}
            & ~(four_drive & ~next_s.four_pin_data_latch);
        next_s.irq_line = four_level;

        three_drive = next_s.three_pin_direction & {3{~float_active}};
        // The open-drain pin only ever pulls low; a one releases it.
        three_drive[`DGP_OD_PIN] = three_drive[`DGP_OD_PIN]
            & ~next_s.three_pin_data_latch[`DGP_OD_PIN]
            & ~next_s.external_reset_select_bit;
        next_s.three_oe = three_drive;
        next_s.three_out = next_s.three_pin_data_latch;
        next_s.three_out[`DGP_OD_PIN] = 1'h0;
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            s <= '0;
            s.four_pin_direction <= `DGP_FOUR_RESET;
            s.three_pin_direction <= `DGP_THREE_RESET;
            s.four_pin_data_latch <= `DGP_FOUR_RESET;
            s.three_pin_data_latch <= `DGP_THREE_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign AWREADY = s.wr_ready;
    assign WREADY = s.wr_ready;
    assign BVALID = s.bvalid;
    assign BRESP = s.bresp;
    assign ARREADY = s.ar_ready;
    assign RVALID = s.rvalid;
    assign RDATA = {24'h000000, s.rdata};
    assign RRESP = s.rresp;
    assign FOUR_PIN_OUT = s.four_out;
    assign FOUR_PIN_OE = s.four_oe;
    assign FOUR_PIN_PULLUP = s.four_pullup;
    assign EXT_IRQ_LINE = s.irq_line;
    assign THREE_PIN_OUT = s.three_out;
    assign THREE_PIN_OE = s.three_oe;

    // Checks next to the logic they guard.

    reset_inputs_a: assert property (
        @(posedge CORE_CLK) disable iff (1'h0)
        $past(SYS_RST) |-> (FOUR_PIN_OE == 4'h0) && (THREE_PIN_OE == 3'h0)
    ) else $error("Pins not all inputs after reset");

    drive_dir_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (!s.standby_pin_float_bit && !$past(s.standby_pin_float_bit))
            |-> FOUR_PIN_OE == s.four_pin_direction
    ) else $error("Four-pin drive does not follow direction");

    out_latch_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        ((FOUR_PIN_OE & (FOUR_PIN_OUT ^ s.four_pin_data_latch)) == 4'h0)
    ) else $error("Driven pin differs from latch");

    write_latch_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (s.wr_ready && WSTRB[0] && word_of(AWADDR) == `DGP_OFS_FOUR_DATA)
            |=> (s.four_pin_data_latch == $past(WDATA[3:0])) && BVALID
    ) else $error("Data write lost");

    read_mix_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (s.ar_ready && word_of(ARADDR) == `DGP_OFS_FOUR_DATA)
            |=> RVALID && RDATA[3:0] == (($past(s.four_pin_data_latch)
            & $past(s.four_pin_direction)) | ($past(four_level)
            & ~$past(s.four_pin_direction)))
    ) else $error("Data read mixes latch and pin wrongly");

    rmw_view_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (s.ar_ready && word_of(ARADDR) == `DGP_OFS_THREE_VIEW)
            |=> RDATA[2:0] == $past(s.three_pin_data_latch)
    ) else $error("Latch view read wrong");

    float_pins_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (STANDBY_MODE && s.standby_pin_float_bit)
            |=> FOUR_PIN_OE == 4'h0 && THREE_PIN_OE == 3'h0 && FOUR_PIN_PULLUP == 4'h0
            && (EXT_IRQ_LINE & ~$past(EXT_IRQ_ENABLE)) == 4'h0
    ) else $error("Pins not floated in standby");

    wake_path_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (STANDBY_MODE && s.standby_pin_float_bit)
            |=> (EXT_IRQ_LINE & $past(EXT_IRQ_ENABLE))
            == ($past(pin_bus.synced.four) & $past(EXT_IRQ_ENABLE))
    ) else $error("Wake-up input blocked");

    pullup_low_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (FOUR_PIN_PULLUP & FOUR_PIN_OE & ~FOUR_PIN_OUT) == 4'h0
    ) else $error("Pull-up on while driving low");

    open_drain_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        !THREE_PIN_OUT[`DGP_OD_PIN]
            && !(THREE_PIN_OE[`DGP_OD_PIN] && s.three_pin_data_latch[`DGP_OD_PIN])
    ) else $error("Open-drain pin driven high");

    reset_pin_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (s.external_reset_select_bit && s.ar_ready
            && word_of(ARADDR) == `DGP_OFS_THREE_DATA)
            |=> !RDATA[`DGP_OD_PIN] && !THREE_PIN_OE[`DGP_OD_PIN]
    ) else $error("Reset pin still acts as port");

    upper_zero_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (s.ar_ready && word_of(ARADDR) == `DGP_OFS_FOUR_DIR)
            |=> RDATA[31:4] == 28'h0000000
    ) else $error("Unimplemented bits read nonzero");

endmodule : dgp_port

// ==== hw/dgp_map.svh ====
// Purpose: Register offsets, field positions, reset values and answer codes of the port block.
// Assumes: Byte addresses on an AXI4-Lite bus with 32-bit data, one aligned word per register.
// Notes: Behaviour
`ifndef DGP_MAP_SVH
`define DGP_MAP_SVH

`define DGP_OFS_FOUR_DATA 8'h00
`define DGP_OFS_FOUR_DIR 8'h04
`define DGP_OFS_FOUR_PULL 8'h08
`define DGP_OFS_THREE_DATA 8'h0C
`define DGP_OFS_THREE_DIR 8'h10
`define DGP_OFS_CTRL 8'h14
`define DGP_OFS_FOUR_VIEW 8'h18
`define DGP_OFS_THREE_VIEW 8'h1C

`define DGP_CTRL_FLOAT_BIT 0
`define DGP_CTRL_RSTSEL_BIT 1
`define DGP_OD_PIN 2

`define DGP_FOUR_RESET 4'h0
`define DGP_THREE_RESET 3'h0
`define DGP_RESP_OKAY 2'h0
`define DGP_RESP_SLVERR 2'h2

`endif

// ==== hw/dgp_pkg.sv ====
// Purpose: Shared types of the port block.
// Assumes: Four-pin port and three-pin port.
// Notes: Pin vector packs the four-pin port above the three-pin port.
package dgp_pkg;

    typedef struct packed {
        logic [3:0] four;
        logic [2:0] three;
    } dgp_pins_t;

    typedef struct packed {
        dgp_pins_t first;
        dgp_pins_t second;
    } dgp_sync_state_t;

    typedef struct packed {
        logic [3:0] four_pin_data_latch;
        logic [3:0] four_pin_direction;
        logic [3:0] four_pin_pullup_enable;
        logic [2:0] three_pin_data_latch;
        logic [2:0] three_pin_direction;
        logic standby_pin_float_bit;
        logic external_reset_select_bit;
        logic wr_ready;
        logic bvalid;
        logic [1:0] bresp;
        logic ar_ready;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic [3:0] four_out;
        logic [3:0] four_oe;
        logic [3:0] four_pullup;
        logic [3:0] irq_line;
        logic [2:0] three_out;
        logic [2:0] three_oe;
    } dgp_state_t;

endpackage : dgp_pkg

// ==== hw/dgp_pin_if.sv ====
// Purpose: Carries raw and synchronised pin levels between the core and the synchroniser.
// Assumes: Raw levels come straight from the pads.
// Notes: Only the synchronised vector may be read by port logic.
`timescale 1ns/10ps
interface dgp_pin_if;
    dgp_pkg::dgp_pins_t raw;
    dgp_pkg::dgp_pins_t synced;
    modport sync_side (input raw, output synced);
    modport core_side (output raw, input synced);
endinterface : dgp_pin_if

// ==== hw/dgp_pin_sync.sv ====
// Purpose: Two-stage synchroniser for all seven pad inputs.
// Assumes: Pads change without regard to CORE_CLK.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/10ps
module dgp_pin_sync (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    dgp_pin_if.sync_side pins
);
    import dgp_pkg::*;

    dgp_sync_state_t s;
    dgp_sync_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.first = pins.raw;
        next_s.second = s.first;
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign pins.synced = s.second;

endmodule : dgp_pin_sync

// ==== testbench/dgp_pin_model.sv ====
// Purpose: Board-side model of the seven pads of the port block.
// Assumes: Levels settle one CORE_CLK edge after the drivers change.
// Notes: An undriven pin without pull-up toggles every cycle so it never reads as a stable level.
`timescale 1ns/10ps
module dgp_pin_model (
    input wire logic clk,
    input wire logic [3:0] four_out,
    input wire logic [3:0] four_oe,
    input wire logic [3:0] four_pullup,
    input wire logic [2:0] three_out,
    input wire logic [2:0] three_oe,
    input wire logic [3:0] ext_four,
    input wire logic [3:0] ext_four_en,
    input wire logic [2:0] ext_three,
    input wire logic [2:0] ext_three_en,
    output logic [3:0] four_in,
    output logic [2:0] three_in
);
    initial begin
        four_in = 4'h0;
        three_in = 3'h0;
    end
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (four_oe[i]) begin
                four_in[i] <= four_out[i];
            end else if (ext_four_en[i]) begin
                four_in[i] <= ext_four[i];
            end else if (four_pullup[i]) begin
                four_in[i] <= 1'h1;
            end else begin
                four_in[i] <= ~four_in[i];
            end
        end
        for (int i = 0; i < 3; i++) begin
            if (three_oe[i]) begin
                three_in[i] <= (i == 2) ? 1'h0 : three_out[i];
            end else if (ext_three_en[i]) begin
                three_in[i] <= ext_three[i];
            end else begin
                // The open-drain pin has a board pull-up; the others float.
                three_in[i] <= (i == 2) ? 1'h1 : ~three_in[i];
            end
        end
    end
endmodule : dgp_pin_model

// ==== testbench/dual_gpio_port_with_standby_tb.sv ====
// Purpose: Self-checking bench of the port block over AXI4-Lite and the pads.
// Assumes: Driven pad levels need four cycles to reach read data: one in the pad model, two in the synchroniser, one in read data.
// Notes: External drivers are off on output pins, as software would arrange.
`timescale 1ns/10ps
`include "dgp_map.svh"
module dual_gpio_port_with_standby_tb;
    localparam logic [1:0] OK = `DGP_RESP_OKAY;
    localparam logic [1:0] ERR = `DGP_RESP_SLVERR;
    logic clk, rst, awvalid, wvalid, bready, arvalid, rready, standby;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata;
    logic [3:0] wstrb, irq_en, ext_four, ext_four_en;
    logic [2:0] ext_three, ext_three_en;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0] four_in, four_out, four_oe, four_pullup, irq_line;
    logic [2:0] three_in, three_out, three_oe;
    int mismatches = 0;
    int tests_run = 0;

    dgp_port u_dut (.CORE_CLK(clk), .SYS_RST(rst), .AWADDR(awaddr), .AWVALID(awvalid),
        .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
        .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .STANDBY_MODE(standby), .EXT_IRQ_ENABLE(irq_en), .FOUR_PIN_IN(four_in),
        .FOUR_PIN_OUT(four_out), .FOUR_PIN_OE(four_oe), .FOUR_PIN_PULLUP(four_pullup),
        .EXT_IRQ_LINE(irq_line), .THREE_PIN_IN(three_in), .THREE_PIN_OUT(three_out),
        .THREE_PIN_OE(three_oe));
    dgp_pin_model u_pins (.clk(clk), .four_out(four_out), .four_oe(four_oe),
        .four_pullup(four_pullup), .three_out(three_out), .three_oe(three_oe),
        .ext_four(ext_four), .ext_four_en(ext_four_en), .ext_three(ext_three),
        .ext_three_en(ext_three_en), .four_in(four_in), .three_in(three_in));

    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    // Entered just after an edge; holds each channel until its ready is sampled.
    // Response ready stays high between transfers, so back-to-back calls never
    // drive it twice in one time step.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        repeat (50) begin
            @(posedge clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) begin
                chk("write response", {30'h0, bresp}, {30'h0, er});
                return;
            end
        end
        chk("write answer", 32'h0, 32'h1);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        repeat (50) begin
            @(posedge clk);
            if (arready) arvalid <= 1'h0;
            if (rvalid) begin
                chk("read response", {30'h0, rresp}, {30'h0, er});
                chk("read data", rdata, exp);
                return;
            end
        end
        chk("read answer", 32'h0, 32'h1);
    endtask : rd

    task automatic t_reset;
        for (int i = 0; i < 8; i++) rd(8'(i * 4), 32'h0, OK);
        chk("oe after reset", {25'h0, four_oe, three_oe}, 32'h0);
        $display("reset values done");
    endtask : t_reset

    task automatic t_out;
        ext_four_en <= 4'h0;
        wr(`DGP_OFS_FOUR_DIR, 32'hFFFF_FFFF, OK);
        rd(`DGP_OFS_FOUR_DIR, 32'h0000_000F, OK);
        wr(`DGP_OFS_FOUR_DATA, 32'h0000_00A5, OK);
        chk("four out", {28'h0, four_out}, 32'h5);
        chk("four oe", {28'h0, four_oe}, 32'hF);
        cyc(5);
        rd(`DGP_OFS_FOUR_DATA, 32'h5, OK);
        $display("output port done");
    endtask : t_out

    task automatic t_in;
        ext_four <= 4'h4;
        ext_four_en <= 4'hC;
        wr(`DGP_OFS_FOUR_DIR, 32'h3, OK);
        wr(`DGP_OFS_FOUR_DATA, 32'h1, OK);
        cyc(5);
        rd(`DGP_OFS_FOUR_DATA, 32'h5, OK);
        rd(`DGP_OFS_FOUR_VIEW, 32'h1, OK);
        chk("irq lines", {28'h0, irq_line}, 32'h5);
        wr(`DGP_OFS_FOUR_DATA, 32'hD, OK);
        chk("oe held", {28'h0, four_oe}, 32'h3);
        rd(`DGP_OFS_FOUR_VIEW, 32'hD, OK);
        wr(`DGP_OFS_FOUR_PULL, 32'hF, OK);
        chk("pullups", {28'h0, four_pullup}, 32'hD);
        $display("input port done");
    endtask : t_in

    task automatic t_stby;
        ext_four <= 4'h8;
        ext_four_en <= 4'h8;
        irq_en <= 4'h8;
        wr(`DGP_OFS_CTRL, 32'h1, OK);
        standby <= 1'h1;
        cyc(5);
        chk("float oe", {21'h0, four_oe, four_pullup, three_oe}, 32'h0);
        chk("wake line", {28'h0, irq_line}, 32'h8);
        standby <= 1'h0;
        wr(`DGP_OFS_CTRL, 32'h0, OK);
        standby <= 1'h1;
        cyc(3);
        chk("held oe", {28'h0, four_oe}, 32'h3);
        chk("held out", {28'h0, four_out}, 32'hD);
        standby <= 1'h0;
        $display("standby done");
    endtask : t_stby

    task automatic t_three;
        ext_three_en <= 3'h0;
        wr(`DGP_OFS_THREE_DIR, 32'h7, OK);
        wr(`DGP_OFS_THREE_DATA, 32'h7, OK);
        chk("od released", {26'h0, three_out, three_oe}, 32'h1B);
        cyc(5);
        rd(`DGP_OFS_THREE_DATA, 32'h7, OK);
        wr(`DGP_OFS_THREE_DATA, 32'h3, OK);
        chk("od low", {29'h0, three_oe}, 32'h7);
        wr(`DGP_OFS_CTRL, 32'h2, OK);
        chk("reset pin oe", {29'h0, three_oe}, 32'h3);
        rd(`DGP_OFS_THREE_DATA, 32'h3, OK);
        $display("three-pin port done");
    endtask : t_three

    task automatic t_err;
        wr(8'h20, 32'hFF, ERR);
        rd(8'h20, 32'h0, ERR);
        // A write with the low byte strobe off is answered but must change nothing.
        wstrb <= 4'h0;
        wr(`DGP_OFS_THREE_DIR, 32'h0, OK);
        wstrb <= 4'hF;
        rd(`DGP_OFS_THREE_DIR, 32'h7, OK);
        rst <= 1'h1;
        cyc(2);
        rst <= 1'h0;
        cyc(1);
        rd(`DGP_OFS_FOUR_DIR, 32'h0, OK);
        chk("oe reset", {25'h0, four_oe, three_oe}, 32'h0);
        $display("error and reset done");
    endtask : t_err

    task automatic end_sim;
        $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        rst = 1'h1;
        {awvalid, wvalid, bready, arvalid, rready, standby} = 6'h0;
        awaddr = 8'h0;
        araddr = 8'h0;
        wdata = 32'h0;
        wstrb = 4'hF;
        irq_en = 4'h0;
        ext_four = 4'h0;
        ext_four_en = 4'hF;
        ext_three = 3'h0;
        ext_three_en = 3'h7;
        cyc(2);
        rst <= 1'h0;
        cyc(1);
        t_reset();
        t_out();
        t_in();
        t_stby();
        t_three();
        t_err();
        end_sim();
    end

    // Whole run needs well under a thousand cycles.
    initial begin
        cyc(5000);
        mismatches++;
        end_sim();
    end
endmodule : dual_gpio_port_with_standby_tb
